/* hdl/olc_ctrl.v */
// low-speed control of a four-lane optical module: 2-wire slave,
// reset sequencer, power limit, presence and attention pins
// assumes host-side pull-ups on data and attention lines
`timescale 1ns/1ps
`include "olc_regs.vh"

// Summary of operation
// - answer bus only while select held low
// - host reads and writes memory over bus
// - long reset pulse restores memory, flag and not-ready defaults
// - completion raises attention, clears not-ready
// - power-up posts completion without reset pulse
// - low-power input limits allowed power
// - presence line tied low when inserted
// - attention low flags fault or status
// - attention is open collector, pulled low
module olc_ctrl #(
  parameter [15:0] INIT_CYCLES = `OLC_INIT_CYC
) (
  input wire clk_in,
  input wire sys_rst_in,
  input wire module_select_n_in,
  input wire module_reset_n_in,
  input wire low_power_select_in,
  input wire scl_in,
  input wire sda_in,
  input wire fault_event_in,
  output wire sda_out,
  output wire sda_oe_out,
  output wire attention_n_out,
  output wire attention_oe_out,
  output wire module_present_n_out,
  output wire high_power_allow_out
);
  localparam [7:0] RST_MIN = `OLC_RST_MIN_CYC;
  wire [4:0] sync_w;

  olc_sync #(.W(5), .INIT(5'b01111)) u_sync (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .async_in({low_power_select_in, module_reset_n_in,
      module_select_n_in, sda_in, scl_in}),
    .sync_out(sync_w)
  );
  wire scl_s = sync_w[0];
  wire sda_s = sync_w[1];
  wire sel_n_s = sync_w[2];
  wire rst_n_s = sync_w[3];
  wire lp_s = sync_w[4];

  // bus edge detection on synchronised copies only
  reg scl_d_reg;
  reg sda_d_reg;
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end
  wire scl_rise = scl_s & ~scl_d_reg;
  wire scl_fall = ~scl_s & scl_d_reg;
  wire bus_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire bus_stop = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // reset sequencer
  reg [1:0] rs_state_reg;
  reg [7:0] lo_cnt_reg;
  reg [15:0] init_cnt_reg;
  reg not_ready_reg;
  reg [7:0] flags_reg;
  reg rd_flags_reg;
  wire long_low = ~rst_n_s & (lo_cnt_reg == RST_MIN - 8'h01);
  reg [7:0] flag_set;
  always @* begin
    flag_set = 8'h00;
    flag_set[`OLC_FLAG_FAULT] = fault_event_in;
    flag_set[`OLC_FLAG_RST_DONE] = (rs_state_reg == `OLC_RS_INIT) &&
      (init_cnt_reg == INIT_CYCLES - 16'h0001);
  end

  // system reset lands in INIT, so power-up posts on its own
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rs_state_reg <= `OLC_RS_INIT;
      lo_cnt_reg <= 8'h00;
      init_cnt_reg <= 16'h0000;
      not_ready_reg <= 1'b1;
      flags_reg <= 8'h00;
    end else begin
      if (rst_n_s)
        lo_cnt_reg <= 8'h00;
      else if (lo_cnt_reg != RST_MIN - 8'h01)
        lo_cnt_reg <= lo_cnt_reg + 8'h01;
      if (long_low) begin
        rs_state_reg <= `OLC_RS_HOLD;
        not_ready_reg <= 1'b1;
        flags_reg <= 8'h00;
      end else begin
        case (rs_state_reg)
          `OLC_RS_HOLD: begin
            if (rst_n_s) begin
              rs_state_reg <= `OLC_RS_INIT;
              init_cnt_reg <= 16'h0000;
            end
          end
          `OLC_RS_INIT: begin
            init_cnt_reg <= init_cnt_reg + 16'h0001;
            if (flag_set[`OLC_FLAG_RST_DONE]) begin
              rs_state_reg <= `OLC_RS_RUN;
              not_ready_reg <= 1'b0;
            end
          end
          `OLC_RS_RUN: ;
          default: rs_state_reg <= `OLC_RS_HOLD;
        endcase
        // set wins over clear-on-read
        flags_reg <= (flags_reg & {8{~rd_flags_reg}}) | flag_set;
      end
    end
  end

  // management memory; low bytes are read-only views
  reg [7:0] mem [0:`OLC_MEM_DEPTH-1];
  reg wr_pulse_reg;
  reg [3:0] wr_idx_reg;
  reg [7:0] wr_data_reg;
  integer k;
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      for (k = 0; k < `OLC_MEM_DEPTH; k = k + 1)
        mem[k] <= 8'h00;
    end else if (rs_state_reg == `OLC_RS_HOLD) begin
      for (k = 0; k < `OLC_MEM_DEPTH; k = k + 1)
        mem[k] <= 8'h00;
    end else if (wr_pulse_reg && wr_idx_reg >= `OLC_OFS_CTRL) begin
      mem[wr_idx_reg] <= wr_data_reg;
    end
  end

  reg [7:0] ptr_reg;
  reg [7:0] rdata;
  always @* begin
    rdata = 8'h00;
    if (ptr_reg[7:4] == 4'h0) begin
      case (ptr_reg[3:0])
        `OLC_OFS_ID: rdata = `OLC_ID_VALUE;
        `OLC_OFS_STATUS: begin
          rdata[`OLC_STAT_NOT_READY] = not_ready_reg;
          rdata[`OLC_STAT_LOW_POWER] = lp_s;
        end
        `OLC_OFS_FLAGS: rdata = flags_reg;
        default: rdata = mem[ptr_reg[3:0]];
      endcase
    end
  end

  // serial engine; data driven only on falling clock edges
  reg [3:0] ss_state_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg rw_reg;
  reg nack_reg;
  reg sda_oe_reg;
  wire rx_state = (ss_state_reg == `OLC_SS_DEVADDR) ||
    (ss_state_reg == `OLC_SS_PTR) || (ss_state_reg == `OLC_SS_WDATA);
  wire ptr_flags = (ptr_reg == {4'h0, `OLC_OFS_FLAGS});

  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ss_state_reg <= `OLC_SS_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      rw_reg <= 1'b0;
      nack_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      wr_pulse_reg <= 1'b0;
      wr_idx_reg <= 4'h0;
      wr_data_reg <= 8'h00;
      rd_flags_reg <= 1'b0;
    end else begin
      wr_pulse_reg <= 1'b0;
      rd_flags_reg <= 1'b0;
      if (sel_n_s) begin
        // not selected: stay off the bus
        ss_state_reg <= `OLC_SS_IDLE;
        sda_oe_reg <= 1'b0;
      end else if (bus_start) begin
        ss_state_reg <= `OLC_SS_DEVADDR;
        bit_cnt_reg <= 4'h0;
        sda_oe_reg <= 1'b0;
      end else if (bus_stop) begin
        ss_state_reg <= `OLC_SS_IDLE;
        sda_oe_reg <= 1'b0;
      end else if (scl_rise) begin
        if (rx_state) begin
          shift_reg <= {shift_reg[6:0], sda_s};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end else if (ss_state_reg == `OLC_SS_RACK) begin
          nack_reg <= sda_s;
        end
      end else if (scl_fall) begin
        case (ss_state_reg)
          `OLC_SS_DEVADDR: begin
            if (bit_cnt_reg == 4'h8) begin
              if (shift_reg[7:1] == `OLC_DEV_ADDR) begin
                sda_oe_reg <= 1'b1;
                rw_reg <= shift_reg[0];
                ss_state_reg <= `OLC_SS_ACK_A;
              end else begin
                ss_state_reg <= `OLC_SS_IDLE;
              end
            end
          end
          `OLC_SS_ACK_A, `OLC_SS_RACK: begin
            bit_cnt_reg <= 4'h0;
            if (ss_state_reg == `OLC_SS_ACK_A && !rw_reg) begin
              sda_oe_reg <= 1'b0;
              ss_state_reg <= `OLC_SS_PTR;
            end else if (ss_state_reg == `OLC_SS_RACK && nack_reg) begin
              sda_oe_reg <= 1'b0;
              ss_state_reg <= `OLC_SS_IDLE;
            end else begin
              // load next byte; reading flags clears them
              shift_reg <= rdata;
              sda_oe_reg <= ~rdata[7];
              bit_cnt_reg <= 4'h1;
              ptr_reg <= ptr_reg + 8'h01;
              rd_flags_reg <= ptr_flags;
              ss_state_reg <= `OLC_SS_RDATA;
            end
          end
          `OLC_SS_PTR, `OLC_SS_WDATA: begin
            if (bit_cnt_reg == 4'h8) begin
              sda_oe_reg <= 1'b1;
              if (ss_state_reg == `OLC_SS_PTR) begin
                ptr_reg <= shift_reg;
                ss_state_reg <= `OLC_SS_ACK_P;
              end else begin
                // out-of-range pointers are acked but dropped
                wr_pulse_reg <= (ptr_reg[7:4] == 4'h0);
                wr_idx_reg <= ptr_reg[3:0];
                wr_data_reg <= shift_reg;
                ptr_reg <= ptr_reg + 8'h01;
                ss_state_reg <= `OLC_SS_ACK_W;
              end
            end
          end
          `OLC_SS_ACK_P, `OLC_SS_ACK_W: begin
            sda_oe_reg <= 1'b0;
            bit_cnt_reg <= 4'h0;
            ss_state_reg <= `OLC_SS_WDATA;
          end
          `OLC_SS_RDATA: begin
            if (bit_cnt_reg == 4'h8) begin
              sda_oe_reg <= 1'b0;
              ss_state_reg <= `OLC_SS_RACK;
            end else begin
              sda_oe_reg <= ~shift_reg[6];
              shift_reg <= {shift_reg[6:0], 1'b0};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
          `OLC_SS_IDLE: ;
          default: ss_state_reg <= `OLC_SS_IDLE;
        endcase
      end
    end
  end

  // pin outputs
  reg attn_reg;
  reg high_power_reg;
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      attn_reg <= 1'b0;
      high_power_reg <= 1'b0;
    end else begin
      attn_reg <= |flags_reg;
      // held at low power until ready, or when host or memory asks
      high_power_reg <= ~lp_s & ~not_ready_reg &
        ~mem[`OLC_OFS_CTRL][`OLC_CTRL_FORCE_LP];
    end
  end
  assign sda_out = 1'b0;
  assign sda_oe_out = sda_oe_reg;
  assign attention_n_out = 1'b0;
  assign attention_oe_out = attn_reg;
  assign module_present_n_out = 1'b0;
  assign high_power_allow_out = high_power_reg;
endmodule // olc_ctrl

/* pkg/olc_regs.vh */
// constants for the module low-speed control block
// assumes a 25 MHz system clock and a host-driven 2-wire bus
`ifndef OLC_REGS_VH
`define OLC_REGS_VH

// least reset pulse on the reset pin: 2 us at 25 MHz
// sized to its counter, so nothing is cut on assignment
`define OLC_RST_MIN_CYC 8'h32
// longest time from reset release to completion: 2 ms at 25 MHz
`define OLC_INIT_CYC 16'hc350

// 7-bit bus address of the management memory
`define OLC_DEV_ADDR 7'h50
// identifier byte, arbitrary value
`define OLC_ID_VALUE 8'h5a

// memory map
`define OLC_MEM_DEPTH 16
`define OLC_OFS_ID 4'h0
`define OLC_OFS_STATUS 4'h2
`define OLC_OFS_FLAGS 4'h3
`define OLC_OFS_CTRL 4'h4
`define OLC_STAT_NOT_READY 0
`define OLC_STAT_LOW_POWER 1
`define OLC_FLAG_RST_DONE 0
`define OLC_FLAG_FAULT 1
`define OLC_CTRL_FORCE_LP 0

// reset sequencer states
`define OLC_RS_HOLD 2'h0
`define OLC_RS_INIT 2'h1
`define OLC_RS_RUN 2'h2

// serial engine states
`define OLC_SS_IDLE 4'h0
`define OLC_SS_DEVADDR 4'h1
`define OLC_SS_ACK_A 4'h2
`define OLC_SS_PTR 4'h3
`define OLC_SS_ACK_P 4'h4
`define OLC_SS_WDATA 4'h5
`define OLC_SS_ACK_W 4'h6
`define OLC_SS_RDATA 4'h7
`define OLC_SS_RACK 4'h8

`endif

/* hdl/olc_sync.v */
// two-flop synchroniser, one per bit
// assumes inputs come from outside the clk_in domain
`timescale 1ns/1ps
module olc_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input wire clk_in,
  input wire sys_rst_in,
  input wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg meta_reg;
      reg sync_reg;
      always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          meta_reg <= INIT[i];
          sync_reg <= INIT[i];
        end else begin
          meta_reg <= async_in[i];
          sync_reg <= meta_reg;
        end
      end
      assign sync_out[i] = sync_reg;
    end
  endgenerate
endmodule // olc_sync

/* bench/olc_host.sv */
// host-side 2-wire master model, data line with pull-up
// assumes the device pulls data low only through its enable
`timescale 1ns/1ps
module olc_host (
  input wire dev_oe_in,
  output logic scl_out,
  output wire sda_out
);
  int hq = 80;
  logic drv;
  // a released line floats high, never holds a stale level
  assign sda_out = !(drv || dev_oe_in);
  initial begin
    scl_out = 1'b1;
    drv = 1'b0;
  end
  task automatic start();
    #7 scl_out = 1'b0;
    #(2*hq) drv = 1'b0;
    #(hq) scl_out = 1'b1;
    #(2*hq) drv = 1'b1;
    #(2*hq) scl_out = 1'b0;
  endtask
  task automatic stop();
    scl_out = 1'b0;
    #(2*hq) drv = 1'b1;
    #(hq) scl_out = 1'b1;
    #(2*hq) drv = 1'b0;
    #(2*hq);
  endtask
  // eight bits then acknowledge; a one releases the line
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      scl_out = 1'b0;
      #(2*hq) drv = !tx[i];
      #(hq) scl_out = 1'b1;
      #(hq/2) rx[i] = sda_out;
      #(hq/2);
    end
  endtask
endmodule // olc_host

/* bench/olc_sva.sv */
// pin-level checker for olc_ctrl
// assumes one clk_in domain, bound to every olc_ctrl
`timescale 1ns/1ps
module olc_sva #(
  parameter [15:0] INIT_CYCLES = 16'hc350
) (
  input wire clk_in,
  input wire sys_rst_in,
  input wire module_select_n_in,
  input wire module_reset_n_in,
  input wire low_power_select_in,
  input wire scl_in,
  input wire sda_in,
  input wire fault_event_in,
  input wire sda_out,
  input wire sda_oe_out,
  input wire attention_n_out,
  input wire attention_oe_out,
  input wire module_present_n_out,
  input wire high_power_allow_out
);
  localparam int WMAX = INIT_CYCLES + 16;
  reg [7:0] rcnt_reg;
  reg [16:0] wcnt_reg;
  reg armed_reg;
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // counter, since the init wait is far beyond a delay range
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rcnt_reg <= 8'h00;
      armed_reg <= 1'b1;
      wcnt_reg <= 17'h00000;
    end else begin
      if (module_reset_n_in)
        rcnt_reg <= 8'h00;
      else if (rcnt_reg != 8'hff)
        rcnt_reg <= rcnt_reg + 8'h01;
      if (module_reset_n_in && rcnt_reg >= 8'h3c) begin
        armed_reg <= 1'b1;
        wcnt_reg <= 17'h00000;
      end else if (attention_oe_out)
        armed_reg <= 1'b0;
      else if (armed_reg)
        wcnt_reg <= wcnt_reg + 17'h00001;
    end
  end
  present_tied_a: assert property (module_present_n_out == 1'b0)
    else $error("presence line not tied low");
  att_open_col_a: assert property (attention_n_out == 1'b0)
    else $error("attention drive value not low");
  sda_open_drain_a: assert property (sda_out == 1'b0)
    else $error("data drive value not low");
  sel_quiet_a: assert property (module_select_n_in [*6] |-> !sda_oe_out)
    else $error("data driven while deselected");
  lp_limit_a: assert property (
    low_power_select_in [*6] |-> !high_power_allow_out)
    else $error("full power allowed in low power mode");
  rst_hold_a: assert property (rcnt_reg >= 8'h3c |->
    !attention_oe_out && !high_power_allow_out)
    else $error("outputs not defaulted during long reset");
  not_ready_a: assert property (
    $fell(sys_rst_in) |-> !high_power_allow_out [*8])
    else $error("power allowed before ready");
  post_done_a: assert property (wcnt_reg <= WMAX)
    else $error("reset completion not posted in time");
  fault_att_a: assert property (fault_event_in && module_reset_n_in
    |-> ##[1:3] attention_oe_out)
    else $error("fault did not raise attention");
endmodule // olc_sva

bind olc_ctrl olc_sva #(.INIT_CYCLES(INIT_CYCLES)) i_olc_sva (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in),
  .module_select_n_in(module_select_n_in),
  .module_reset_n_in(module_reset_n_in),
  .low_power_select_in(low_power_select_in), .scl_in(scl_in),
  .sda_in(sda_in), .fault_event_in(fault_event_in), .sda_out(sda_out),
  .sda_oe_out(sda_oe_out), .attention_n_out(attention_n_out),
  .attention_oe_out(attention_oe_out),
  .module_present_n_out(module_present_n_out),
  .high_power_allow_out(high_power_allow_out));

/* bench/olc_ctrl_tb.sv */
// self-checking bench for olc_ctrl with a 2-wire host model
// assumes pull-ups on the data and attention lines
`timescale 1ns/1ps
`include "olc_regs.vh"
module olc_ctrl_tb;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic sel_n = 1'b0;
  logic rst_n = 1'b1;
  logic lp = 1'b0;
  logic fault = 1'b0;
  logic [15:0] lfsr_reg = 16'h7a01;
  wire scl, sda, sda_oe, att_n, att_oe, prs_n, hp;
  wire att_line = att_oe ? att_n : 1'b1;
  int fail_count = 0;
  int tests_run = 0;
  logic [7:0] expq[$];
  string what;
  logic [7:0] seen;
  logic [8:0] r;
  event res_ev;
  always #20 clk_in = ~clk_in;
  olc_ctrl #(.INIT_CYCLES(16'h0014)) i_olc_ctrl (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .module_select_n_in(sel_n), .module_reset_n_in(rst_n),
    .low_power_select_in(lp), .scl_in(scl), .sda_in(sda),
    .fault_event_in(fault), .sda_out(), .sda_oe_out(sda_oe),
    .attention_n_out(att_n), .attention_oe_out(att_oe),
    .module_present_n_out(prs_n), .high_power_allow_out(hp));
  olc_host i_olc_host (.dev_oe_in(sda_oe), .scl_out(scl), .sda_out(sda));
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input string n, input logic [7:0] v,
    input logic [7:0] x);
    tests_run++;
    if (v !== x) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, x, v);
    end
  endtask
  always @(res_ev) check(what, seen, expq.pop_front());
  task automatic note(input string n, input logic [7:0] v,
    input logic [7:0] x);
    expq.push_back(x);
    what = n;
    seen = v;
    -> res_ev;
    #1;
  endtask
  task automatic wr(input logic [7:0] o, input logic [7:0] v);
    i_olc_host.start();
    i_olc_host.xfer({`OLC_DEV_ADDR, 2'b01}, r);
    i_olc_host.xfer({o, 1'b1}, r);
    i_olc_host.xfer({v, 1'b1}, r);
    note("write_ack", {7'h00, r[0]}, 8'h00);
    i_olc_host.stop();
  endtask
  task automatic rd(input logic [7:0] o, input logic [7:0] x);
    i_olc_host.start();
    i_olc_host.xfer({`OLC_DEV_ADDR, 2'b01}, r);
    i_olc_host.xfer({o, 1'b1}, r);
    i_olc_host.start();
    i_olc_host.xfer({`OLC_DEV_ADDR, 2'b11}, r);
    i_olc_host.xfer(9'h1ff, r);
    note("read_data", r[8:1], x);
    i_olc_host.stop();
  endtask
  task automatic wait_att();
    for (int n = 0; n < 200 && att_line !== 1'b0; n++) @(posedge clk_in);
    note("attention", {7'h00, att_line}, 8'h00);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // about 170 us of bus traffic expected, so 1 ms is a hang
  initial begin
    #1000000;
    fail_count++;
    results();
  end
  initial begin
    repeat (20) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    note("present", {7'h00, prs_n}, 8'h00);
    wait_att();
    rd(`OLC_OFS_STATUS, 8'h00);
    rd(`OLC_OFS_FLAGS, 8'h01);
    note("att_released", {7'h00, att_line}, 8'h01);
    $display("test power-up done");
    lfsr_reg = nxt(lfsr_reg);
    wr(8'h05, lfsr_reg[7:0]);
    wr(`OLC_OFS_ID, ~lfsr_reg[7:0]);
    rd(8'h05, lfsr_reg[7:0]);
    rd(`OLC_OFS_ID, `OLC_ID_VALUE);
    rd(8'h20, 8'h00);
    $display("test memory done");
    @(posedge clk_in) sel_n <= 1'b1;
    repeat (4) @(posedge clk_in);
    i_olc_host.start();
    i_olc_host.xfer({`OLC_DEV_ADDR, 2'b01}, r);
    note("deselected_ack", {7'h00, r[0]}, 8'h01);
    i_olc_host.stop();
    @(posedge clk_in) sel_n <= 1'b0;
    $display("test select done");
    @(posedge clk_in) lp <= 1'b1;
    rd(`OLC_OFS_STATUS, 8'h02);
    note("power_lp", {7'h00, hp}, 8'h00);
    @(posedge clk_in) lp <= 1'b0;
    repeat (8) @(posedge clk_in);
    note("power_full", {7'h00, hp}, 8'h01);
    wr(`OLC_OFS_CTRL, 8'h01);
    note("power_forced", {7'h00, hp}, 8'h00);
    wr(`OLC_OFS_CTRL, 8'h00);
    $display("test power done");
    @(posedge clk_in) fault <= 1'b1;
    @(posedge clk_in) fault <= 1'b0;
    wait_att();
    rd(`OLC_OFS_FLAGS, 8'h02);
    $display("test fault done");
    wr(8'h06, 8'h0f);
    @(posedge clk_in) rst_n <= 1'b0;
    repeat (70) @(posedge clk_in);
    note("power_hold", {7'h00, hp}, 8'h00);
    @(posedge clk_in) rst_n <= 1'b1;
    wait_att();
    rd(8'h06, 8'h00);
    rd(`OLC_OFS_FLAGS, 8'h01);
    note("power_ready", {7'h00, hp}, 8'h01);
    $display("test module reset done");
    results();
  end
endmodule // olc_ctrl_tb
